// [lcis_pkg.sv]
package lcis_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] LCIS_ADDR_SEL_ONE_TWO = 12'h000;
    localparam logic [11:0] LCIS_ADDR_SEL_THREE_FOUR = 12'h004;
    localparam logic [11:0] LCIS_ADDR_GATE_ENABLE = 12'h008;
    // field positions inside each select register
    localparam int LCIS_LOW_FIELD_POS = 0;
    localparam int LCIS_HIGH_FIELD_POS = 4;
    // implemented bits of a select register, bits 7 and 3 stay zero
    localparam logic [7:0] LCIS_SEL_MASK = 8'h77;
    // base source line of each channel's group
    localparam logic [3:0] LCIS_BASE_CHAN1 = 4'h0;
    localparam logic [3:0] LCIS_BASE_CHAN2 = 4'h4;
    localparam logic [3:0] LCIS_BASE_CHAN3 = 4'h8;
    localparam logic [3:0] LCIS_BASE_CHAN4 = 4'hc;
endpackage

// [lcis_input_select.sv]
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcis_input_select
    import lcis_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [15:0] source_in,
    output logic [3:0] data_channel_out,
    output logic [3:0] gate_out
);
    // two-stage synchroniser on the source lines
    logic [15:0] src_meta_r;
    logic [15:0] src_sync_r;
    logic [7:0] sel_one_two_r;
    logic [7:0] sel_three_four_r;
    logic [31:0] gate_en_r;
    logic [31:0] prdata_r;
    logic [3:0] chan_r;
    logic [3:0] gate_r;

    // apb decode
    wire logic acc = psel_in && penable_in;
    wire logic hit_a = paddr_in == LCIS_ADDR_SEL_ONE_TWO;
    wire logic hit_b = paddr_in == LCIS_ADDR_SEL_THREE_FOUR;
    wire logic hit_g = paddr_in == LCIS_ADDR_GATE_ENABLE;
    wire logic mapped = hit_a || hit_b || hit_g;
    wire logic wr_a = acc && pwrite_in && hit_a;
    wire logic wr_b = acc && pwrite_in && hit_b;
    wire logic wr_g = acc && pwrite_in && hit_g;
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !mapped;
    assign prdata_out = prdata_r;

    // select fields
    wire logic [2:0] chan1_source_code = sel_one_two_r[LCIS_LOW_FIELD_POS +: 3];
    wire logic [2:0] chan2_source_code = sel_one_two_r[LCIS_HIGH_FIELD_POS +: 3];
    wire logic [2:0] chan3_source_code = sel_three_four_r[LCIS_LOW_FIELD_POS +: 3];
    wire logic [2:0] chan4_source_code = sel_three_four_r[LCIS_HIGH_FIELD_POS +: 3];
    // 4-bit sum wraps naturally, giving channel four its 15->0 roll-over
    wire logic [3:0] idx1 = LCIS_BASE_CHAN1 + {1'b0, chan1_source_code};
    wire logic [3:0] idx2 = LCIS_BASE_CHAN2 + {1'b0, chan2_source_code};
    wire logic [3:0] idx3 = LCIS_BASE_CHAN3 + {1'b0, chan3_source_code};
    wire logic [3:0] idx4 = LCIS_BASE_CHAN4 + {1'b0, chan4_source_code};
    wire logic [3:0] chan_nxt = {src_sync_r[idx4], src_sync_r[idx3], src_sync_r[idx2], src_sync_r[idx1]};
    wire logic data_channel_one = chan_r[0];
    wire logic data_channel_two = chan_r[1];
    wire logic data_channel_three = chan_r[2];
    wire logic data_channel_four = chan_r[3];
    // inverted form in the even bit, true form in the odd bit above it, per channel
    // gate g takes its enables from gate_en_r[8g +: 8], one byte per gate
    wire logic [7:0] chan_forms = {data_channel_four, ~data_channel_four, data_channel_three,
        ~data_channel_three, data_channel_two, ~data_channel_two, data_channel_one, ~data_channel_one};
    logic [3:0] gate_nxt;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gate
            assign gate_nxt[g] = |(chan_forms & gate_en_r[8*g +: 8]);
        end
    endgenerate
    wire logic gate_one_output = gate_r[0];

    wire logic [31:0] rd_nxt = hit_a ? {24'h000000, sel_one_two_r} :
        hit_b ? {24'h000000, sel_three_four_r} : hit_g ? gate_en_r : 32'h00000000;

    // configuration is not on the reset: it keeps its value over resets
    always_ff @(posedge clk_in) begin
        if (wr_a) begin
            sel_one_two_r <= pwdata_in[7:0] & LCIS_SEL_MASK;
        end
        if (wr_b) begin
            sel_three_four_r <= pwdata_in[7:0] & LCIS_SEL_MASK;
        end
        if (wr_g) begin
            gate_en_r <= pwdata_in;
        end
    end

    // synchroniser, channel and gate outputs, read data
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            src_meta_r <= 16'h0000;
            src_sync_r <= 16'h0000;
            chan_r <= 4'h0;
            gate_r <= 4'h0;
            prdata_r <= 32'h00000000;
        end else begin
            src_meta_r <= source_in;
            src_sync_r <= src_meta_r;
            chan_r <= chan_nxt;
            gate_r <= gate_nxt;
            prdata_r <= (psel_in && !penable_in && !pwrite_in) ? rd_nxt : prdata_r;
        end
    end
    assign data_channel_out = chan_r;
    assign gate_out = {gate_r[3:1], gate_one_output};


    // checker helpers only: the select and enable fields power up unknown, so a
    // checker stays quiet until software has written the field it depends on
    logic seen_a_r;
    logic seen_b_r;
    logic seen_g_r;
    logic seen_all_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seen_a_r <= 1'b0;
            seen_b_r <= 1'b0;
            seen_g_r <= 1'b0;
            seen_all_r <= 1'b0;
        end else begin
            seen_a_r <= seen_a_r | wr_a;
            seen_b_r <= seen_b_r | wr_b;
            seen_g_r <= seen_g_r | wr_g;
            // one cycle later, so the channel flops already hold known values
            seen_all_r <= seen_a_r & seen_b_r & seen_g_r;
        end
    end

    // read transfer in two steps: setup captures, access hands the word over
    sequence s_read_setup;
        psel_in && !penable_in && !pwrite_in;
    endsequence
    sequence s_read_access;
        psel_in && penable_in;
    endsequence

    AST_CHAN1: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_a_r |=> chan_r[0] == $past(src_sync_r[{1'b0, chan1_source_code}]))
        else $error("channel one wrong");
    AST_CHAN2: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_a_r |=> chan_r[1] == $past(src_sync_r[idx2])) else $error("channel two wrong");
    AST_CHAN3: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_b_r |=> chan_r[2] == $past(src_sync_r[{1'b1, chan3_source_code}]))
        else $error("channel three wrong");
    AST_CHAN4_WRAP: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_b_r && chan4_source_code[2] |=> chan_r[3] == $past(src_sync_r[{2'b00, chan4_source_code[1:0]}]))
        else $error("channel four wrap wrong");
    AST_RESERVED: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_a_r && seen_b_r |-> ((sel_one_two_r | sel_three_four_r) & ~LCIS_SEL_MASK) == 8'h00)
        else $error("reserved bit set");
    // gate one written out term by term, independent of the packed form vector
    AST_GATE_ONE: assert property (@(posedge clk_in) disable iff (!resetn_in)
        seen_all_r |=> gate_out[0] == $past((gate_en_r[1] & chan_r[0]) | (gate_en_r[0] & ~chan_r[0]) |
        (gate_en_r[3] & chan_r[1]) | (gate_en_r[2] & ~chan_r[1]) | (gate_en_r[5] & chan_r[2]) |
        (gate_en_r[4] & ~chan_r[2]) | (gate_en_r[7] & chan_r[3]) | (gate_en_r[6] & ~chan_r[3])))
        else $error("gate one wrong");
    AST_READ_DATA: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_read_setup ##1 s_read_access |-> prdata_out == $past(rd_nxt)) else $error("read data wrong");
    AST_SLVERR: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_read_access |-> pslverr_out == !mapped) else $error("error response wrong");
endmodule
`default_nettype wire

// [lcis_testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench import lcis_pkg::*; ;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, e;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, q, ge;
    logic [15:0] src = 0;
    logic [7:0] s0, s1;
    logic [3:0] x;
    wire logic [31:0] prd;
    wire logic prdy, perr;
    wire logic [3:0] ch, gt;
    int error_cnt = 0, checks = 0;
    lcis_input_select i_lcis_input_select(.clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .source_in(src), .data_channel_out(ch), .gate_out(gt));
    initial forever #20 clk = ~clk;
    // wrapping 4-bit sum gives the channel four wrap past line 15
    function logic [3:0] exp_ch(logic [7:0] a, logic [7:0] b, logic [15:0] s);
        exp_ch = {s[LCIS_BASE_CHAN4 + b[6:4]], s[LCIS_BASE_CHAN3 + b[2:0]], s[LCIS_BASE_CHAN2 + a[6:4]], s[a[2:0]]};
    endfunction
    // each gate ors the true and inverted channel forms it enables
    function logic [3:0] exp_gt(logic [31:0] en, logic [3:0] c);
        exp_gt = 4'h0;
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 4; k++) exp_gt[g] |= (en[8*g+2*k+1] & c[k]) | (en[8*g+2*k] & ~c[k]);
        end
    endfunction
    // one apb transfer; the leading edge keeps release and next setup apart
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pw <= w; pa <= a; pd <= d;
        @(posedge clk);
        pen <= 1;
        for (int n = 0; n < 50; n++) begin @(posedge clk); if (prdy === 1'b1) break; end
        q = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task finish_test;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // every code of every channel twice, spare bits and sources random
    initial begin
        void'($urandom(32'h75b99b0c));
        repeat (6) @(posedge clk);
        rstn <= 1;
        for (int i = 0; i < 16; i++) begin
            s0 = $urandom; s1 = $urandom; ge = $urandom;
            s0[2:0] = i[2:0]; s0[6:4] = i[3:1]; s1[2:0] = i[2:0]; s1[6:4] = ~i[2:0];
            apb(1'b1, LCIS_ADDR_SEL_ONE_TWO, {24'h0, s0});
            apb(1'b1, LCIS_ADDR_SEL_THREE_FOUR, {24'h0, s1});
            apb(1'b1, LCIS_ADDR_GATE_ENABLE, ge);
            src <= $urandom;
            apb(1'b0, LCIS_ADDR_SEL_ONE_TWO, 32'h0); `CHK(q, {24'h0, s0 & LCIS_SEL_MASK})
            apb(1'b0, LCIS_ADDR_SEL_THREE_FOUR, 32'h0); `CHK(q, {24'h0, s1 & LCIS_SEL_MASK})
            apb(1'b0, LCIS_ADDR_GATE_ENABLE, 32'h0); `CHK(q, ge)
            repeat (5) @(posedge clk);
            #1 x = exp_ch(s0, s1, src);
            `CHK(ch[0], x[0])
            `CHK(ch[1], x[1])
            `CHK(ch[2], x[2])
            `CHK(ch[3], x[3])
            `CHK(gt, exp_gt(ge, x))
        end
        apb(1'b0, 12'h00c, 32'h0); `CHK({e, q}, {1'b1, 32'h0})
        rstn <= 0;
        #1 `CHK(ch, 4'h0)
        @(posedge clk);
        rstn <= 1;
        apb(1'b0, LCIS_ADDR_SEL_THREE_FOUR, 32'h0); `CHK(q, {24'h0, s1 & LCIS_SEL_MASK})
        apb(1'b0, LCIS_ADDR_GATE_ENABLE, 32'h0); `CHK(q, ge)
        finish_test;
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin #200000; error_cnt++; finish_test; end
endmodule
`default_nettype wire
